// ===== rtl/cfb_defs.vh
// Constants for the configuration byte bank and boot segment decode
`ifndef CFB_DEFS_VH
`define CFB_DEFS_VH
`define CFB_ADDR_W 24
`define CFB_CFG_SPACE_LO 24'h800000
`define CFB_BASE 24'hF80000
`define CFB_LAST 24'hF80016
`define CFB_OFS_BOOT 24'hF80000
`define CFB_OFS_SECURE 24'hF80002
`define CFB_OFS_GENERAL 24'hF80004
`define CFB_OFS_INIT_OSC 24'hF80006
`define CFB_OFS_OSC 24'hF80008
`define CFB_OFS_WDT 24'hF8000A
`define CFB_OFS_POR 24'hF8000C
`define CFB_OFS_DEBUG 24'hF8000E
`define CFB_OFS_UID0 24'hF80010
`define CFB_OFS_UID1 24'hF80012
`define CFB_OFS_UID2 24'hF80014
`define CFB_OFS_UID3 24'hF80016
`define CFB_NUM_BYTES 12
`define CFB_IDX_BOOT 0
`define CFB_IDX_SECURE 1
`define CFB_IDX_GENERAL 2
`define CFB_IDX_INIT_OSC 3
`define CFB_IDX_OSC 4
`define CFB_IDX_WDT 5
`define CFB_IDX_POR 6
`define CFB_IDX_DEBUG 7
`define CFB_IDX_UID0 8
`define CFB_IDX_UID1 9
`define CFB_IDX_UID2 10
`define CFB_IDX_UID3 11
`define CFB_ERASED 8'hFF
`define CFB_MASK_BOOT 8'hCF
`define CFB_MASK_SECURE 8'hCF
`define CFB_MASK_GENERAL 8'h07
`define CFB_MASK_INIT_OSC 8'hC7
`define CFB_MASK_OSC 8'hC7
`define CFB_MASK_WDT 8'hFF
`define CFB_MASK_WDT_SMALL 8'hDF
`define CFB_MASK_POR 8'h07
`define CFB_FORCE_POR 8'hE0
`define CFB_MASK_DEBUG 8'hE3
`define CFB_MASK_UID 8'hFF
`define CFB_BIT_WRP 0
`define CFB_BSS_LSB 1
`define CFB_RBS_LSB 6
`define CFB_BOOT_END_1K 24'h0007FE
`define CFB_BOOT_END_4K 24'h001FFE
`define CFB_BOOT_END_8K 24'h003FFE
`define CFB_RAM_NONE 11'h000
`define CFB_RAM_128 11'h080
`define CFB_RAM_256 11'h100
`define CFB_RAM_1024 11'h400
`endif

// ===== rtl/cfb_boot_decode.v
// Boot segment field decoder
`timescale 1ns/100ps
`include "cfb_defs.vh"
module cfb_boot_decode
(
  input wire [7:0] i_boot_byte,
  output reg o_boot_seg_en,
  output reg o_boot_high_sec,
  output reg [23:0] o_boot_seg_end,
  output reg [10:0] o_boot_ram_bytes
);
  wire [2:0] boot_segment_size;
  wire [1:0] boot_ram_size;
  assign boot_segment_size = i_boot_byte[`CFB_BSS_LSB+2:`CFB_BSS_LSB];
  assign boot_ram_size = i_boot_byte[`CFB_RBS_LSB+1:`CFB_RBS_LSB];

  always @*
  begin
    o_boot_seg_en = 1'b1;
    o_boot_high_sec = ~boot_segment_size[2];
    o_boot_seg_end = 24'h000000;
    case (boot_segment_size[1:0])
      2'b10: o_boot_seg_end = `CFB_BOOT_END_1K;
      2'b01: o_boot_seg_end = `CFB_BOOT_END_4K;
      2'b00: o_boot_seg_end = `CFB_BOOT_END_8K;
      default:
      begin
        o_boot_seg_en = 1'b0;
        o_boot_high_sec = 1'b0;
      end
    endcase
  end

  always @*
  begin
    case (boot_ram_size)
      2'b11: o_boot_ram_bytes = `CFB_RAM_NONE;
      2'b10: o_boot_ram_bytes = `CFB_RAM_128;
      2'b01: o_boot_ram_bytes = `CFB_RAM_256;
      default: o_boot_ram_bytes = `CFB_RAM_1024;
    endcase
  end
endmodule // cfb_boot_decode

// ===== rtl/cfb_config_bank.v
// Write-once configuration byte bank with table read and write port
`timescale 1ns/100ps
`include "cfb_defs.vh"
module cfb_config_bank
#(
  parameter SMALL_MEM = 1'b0
)
(
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_tbl_rd,
  input wire i_tbl_wr,
  input wire [23:0] i_tbl_addr,
  input wire [7:0] i_tbl_wdata,
  output reg [7:0] o_tbl_rdata,
  output reg o_tbl_hit,
  output wire o_boot_write_allow,
  output wire o_secure_write_allow,
  output wire o_boot_seg_en,
  output wire o_boot_high_sec,
  output wire [23:0] o_boot_seg_end,
  output wire [10:0] o_boot_ram_bytes
);
  // ****************************************
  // Address decode
  // ****************************************
  wire [`CFB_NUM_BYTES-1:0] hit_vec;
  wire in_bank;
  reg [3:0] idx;
  integer ent;
  // Only table accesses reach this port; instruction fetch has no path here
  assign in_bank = |hit_vec;

  // One-hot entry match turned into the read mux index
  always @*
  begin
    idx = 4'h0;
    for (ent = 0; ent < `CFB_NUM_BYTES; ent = ent + 1)
    begin
      if (hit_vec[ent])
        idx = ent[3:0];
    end
  end

  // ****************************************
  // Storage: cell bit clears once, power cycle restores
  // ****************************************
  reg [7:0] cell_ff [0:`CFB_NUM_BYTES-1];
  reg [7:0] done_ff [0:`CFB_NUM_BYTES-1];

  // Byte address of each entry
  function [23:0] entry_addr;
    input integer ent_num;
    begin
      case (ent_num)
        `CFB_IDX_BOOT: entry_addr = `CFB_OFS_BOOT;
        `CFB_IDX_SECURE: entry_addr = `CFB_OFS_SECURE;
        `CFB_IDX_GENERAL: entry_addr = `CFB_OFS_GENERAL;
        `CFB_IDX_INIT_OSC: entry_addr = `CFB_OFS_INIT_OSC;
        `CFB_IDX_OSC: entry_addr = `CFB_OFS_OSC;
        `CFB_IDX_WDT: entry_addr = `CFB_OFS_WDT;
        `CFB_IDX_POR: entry_addr = `CFB_OFS_POR;
        `CFB_IDX_DEBUG: entry_addr = `CFB_OFS_DEBUG;
        `CFB_IDX_UID0: entry_addr = `CFB_OFS_UID0;
        `CFB_IDX_UID1: entry_addr = `CFB_OFS_UID1;
        `CFB_IDX_UID2: entry_addr = `CFB_OFS_UID2;
        `CFB_IDX_UID3: entry_addr = `CFB_OFS_UID3;
        default: entry_addr = `CFB_OFS_BOOT;
      endcase
    end
  endfunction

  // Implemented bits of each entry; the rest never store and read 0, except POR bits 7:5 which read 1
  function [7:0] entry_mask;
    input integer ent_num;
    begin
      case (ent_num)
        `CFB_IDX_BOOT: entry_mask = `CFB_MASK_BOOT;
        `CFB_IDX_SECURE: entry_mask = `CFB_MASK_SECURE;
        `CFB_IDX_GENERAL: entry_mask = `CFB_MASK_GENERAL;
        `CFB_IDX_INIT_OSC: entry_mask = `CFB_MASK_INIT_OSC;
        `CFB_IDX_OSC: entry_mask = `CFB_MASK_OSC;
        `CFB_IDX_WDT: entry_mask = SMALL_MEM ? `CFB_MASK_WDT_SMALL : `CFB_MASK_WDT;
        `CFB_IDX_POR: entry_mask = `CFB_MASK_POR;
        `CFB_IDX_DEBUG: entry_mask = `CFB_MASK_DEBUG;
        default: entry_mask = `CFB_MASK_UID;
      endcase
    end
  endfunction

  // Bits that always read 1 whatever was written
  function [7:0] entry_force;
    input integer ent_num;
    begin
      if (ent_num == `CFB_IDX_POR)
        entry_force = `CFB_FORCE_POR;
      else
        entry_force = 8'h00;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `CFB_NUM_BYTES; g = g + 1)
    begin : g_cell
      wire sel;
      wire [7:0] nxt_cell;
      wire [7:0] nxt_done;
      wire [7:0] wr_bits;
      assign hit_vec[g] = (i_tbl_addr == entry_addr(g));
      assign sel = i_tbl_wr && hit_vec[g];
      // Bits already written this power cycle are locked
      assign wr_bits = sel ? (entry_mask(g) & ~done_ff[g]) : 8'h00;
      assign nxt_cell = (cell_ff[g] & ~wr_bits) | (i_tbl_wdata & wr_bits & cell_ff[g]);
      assign nxt_done = done_ff[g] | wr_bits;
      always @(posedge i_clk_sys)
      begin
        if (i_rst)
        begin
          cell_ff[g] <= `CFB_ERASED;
          done_ff[g] <= 8'h00;
        end
        else
        begin
          cell_ff[g] <= nxt_cell;
          done_ff[g] <= nxt_done;
        end
      end
    end
  endgenerate

  // ****************************************
  // Table read port
  // ****************************************
  reg [7:0] nxt_rdata;
  always @*
  begin
    nxt_rdata = o_tbl_rdata;
    if (i_tbl_rd)
    begin
      if (in_bank)
        nxt_rdata = (cell_ff[idx] & entry_mask(idx)) | entry_force(idx);
      else
        nxt_rdata = 8'h00;
    end
  end

  always @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_tbl_rdata <= 8'h00;
      o_tbl_hit <= 1'b0;
    end
    else
    begin
      o_tbl_rdata <= nxt_rdata;
      o_tbl_hit <= (i_tbl_rd || i_tbl_wr) && in_bank;
    end
  end

  // ****************************************
  // Protection outputs
  // ****************************************
  wire [7:0] boot_byte;
  assign boot_byte = cell_ff[`CFB_IDX_BOOT] & `CFB_MASK_BOOT;
  assign o_boot_write_allow = boot_byte[`CFB_BIT_WRP];
  assign o_secure_write_allow = cell_ff[`CFB_IDX_SECURE][`CFB_BIT_WRP];

  cfb_boot_decode u_boot_decode
  (
    .i_boot_byte(boot_byte),
    .o_boot_seg_en(o_boot_seg_en),
    .o_boot_high_sec(o_boot_high_sec),
    .o_boot_seg_end(o_boot_seg_end),
    .o_boot_ram_bytes(o_boot_ram_bytes)
  );
endmodule // cfb_config_bank

// ===== tb/cfb_props.sv
// Port checker for the configuration bank
`timescale 1ns/100ps
module cfb_props (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_tbl_rd,
  input wire i_tbl_wr,
  input wire o_tbl_hit,
  input wire o_boot_write_allow,
  input wire o_secure_write_allow,
  input wire o_boot_seg_en,
  input wire o_boot_high_sec,
  input wire [23:0] i_tbl_addr,
  input wire [23:0] o_boot_seg_end,
  input wire [7:0] i_tbl_wdata,
  input wire [7:0] o_tbl_rdata,
  input wire [10:0] o_boot_ram_bytes
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire acc = i_tbl_rd | i_tbl_wr;
  wire bank = !i_tbl_addr[0] && i_tbl_addr >= 24'hF80000 && i_tbl_addr <= 24'hF80016;
  property p_hit; o_tbl_hit |-> $past(acc & bank); endproperty
  a_hit: assert property (p_hit) else $error("stray hit");
  property p_miss; acc & !bank |=> !o_tbl_hit; endproperty
  a_miss: assert property (p_miss) else $error("hit off bank");
  property p_gen; i_tbl_rd & i_tbl_addr == 24'hF80004 |=> o_tbl_rdata[7:3] == 5'h00; endproperty
  a_gen: assert property (p_gen) else $error("general bits");
  property p_por; i_tbl_rd & i_tbl_addr == 24'hF8000C |=> &o_tbl_rdata[7:5]; endproperty
  a_por: assert property (p_por) else $error("power-on bits");
  property p_none; !o_boot_seg_en |-> o_boot_seg_end == 24'h0 && !o_boot_high_sec; endproperty
  a_none: assert property (p_none) else $error("no segment");
  property p_end; o_boot_seg_en |-> o_boot_seg_end inside {24'h7FE, 24'h1FFE, 24'h3FFE};
  endproperty
  a_end: assert property (p_end) else $error("segment end");
  property p_bwp; $fell(o_boot_write_allow)
    |-> $past(i_tbl_wr && i_tbl_addr == 24'hF80000 && !i_tbl_wdata[0]); endproperty
  a_bwp: assert property (p_bwp) else $error("boot protect");
  property p_swp; $fell(o_secure_write_allow)
    |-> $past(i_tbl_wr && i_tbl_addr == 24'hF80002 && !i_tbl_wdata[0]); endproperty
  a_swp: assert property (p_swp) else $error("secure protect");
endmodule // cfb_props
bind cfb_config_bank cfb_props chk (.i_clk_sys, .i_rst, .i_tbl_rd, .i_tbl_wr, .o_tbl_hit,
  .o_boot_write_allow, .o_secure_write_allow, .o_boot_seg_en, .o_boot_high_sec,
  .i_tbl_addr, .o_boot_seg_end, .i_tbl_wdata, .o_tbl_rdata, .o_boot_ram_bytes);

// ===== tb/cfb_core_model.sv
// Core model issuing one table access per call
`timescale 1ns/100ps
module cfb_core_model (
  input wire i_clk_sys,
  output reg o_rd = 1'b0,
  output reg o_wr = 1'b0,
  output reg [23:0] o_addr = 24'h0,
  output reg [7:0] o_wdata = 8'h0
);
  task acc(input w, input [23:0] a, input [7:0] d);
    begin
      @(negedge i_clk_sys);
      {o_rd, o_wr, o_addr, o_wdata} = {!w, w, a, d};
      @(negedge i_clk_sys);
      {o_rd, o_wr, o_addr, o_wdata} = {2'b00, ~a, ~d};
    end
  endtask
endmodule // cfb_core_model

// ===== tb/tb_config_fuse_boot_protect.sv
// Self-checking bench for the configuration bank
`timescale 1ns/100ps
module tb_config_fuse_boot_protect;
  reg clk = 1'b0;
  reg rst = 1'b1;
  wire rd, wr, hit, bwa, swa, sen, hs;
  wire [23:0] adr, send;
  wire [7:0] wd, rdat;
  wire hit_s;
  wire [7:0] rdat_s;
  wire [10:0] ram;
  integer bad_count = 0, checks = 0, seed = 32'h45CBCB2F, i, k, n, w;
  integer mem[0:11], lk[0:11];
  reg [95:0] mk = 96'hFF_FF_FF_FF_E3_07_FF_C7_C7_07_CF_CF;
  reg [7:0] d, b, s;
  reg [23:0] a, e_end;
  reg [10:0] e_ram;
  initial forever #25 clk = ~clk;
  cfb_core_model core (.i_clk_sys(clk), .o_rd(rd), .o_wr(wr), .o_addr(adr), .o_wdata(wd));
  cfb_config_bank #(.SMALL_MEM(1'b0)) dut (.i_clk_sys(clk), .i_rst(rst), .i_tbl_rd(rd),
    .i_tbl_wr(wr), .i_tbl_addr(adr), .i_tbl_wdata(wd), .o_tbl_rdata(rdat), .o_tbl_hit(hit),
    .o_boot_write_allow(bwa), .o_secure_write_allow(swa), .o_boot_seg_en(sen),
    .o_boot_high_sec(hs), .o_boot_seg_end(send), .o_boot_ram_bytes(ram));
  cfb_config_bank #(.SMALL_MEM(1'b1)) dut_small (.i_clk_sys(clk), .i_rst(rst),
    .i_tbl_rd(rd), .i_tbl_wr(wr), .i_tbl_addr(adr), .i_tbl_wdata(wd),
    .o_tbl_rdata(rdat_s), .o_tbl_hit(hit_s), .o_boot_write_allow(),
    .o_secure_write_allow(), .o_boot_seg_en(), .o_boot_high_sec(),
    .o_boot_seg_end(), .o_boot_ram_bytes());
  task tally(input ok, input [63:0] g, input [63:0] e);
    begin
      checks = checks + 1;
      if (!ok)
      begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task cmp_rd(input [8:0] g, input [8:0] e); tally(g === e, g, e); endtask
  task cmp_dec(input [39:0] g, input [39:0] e); tally(g === e, g, e); endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial
  begin
    for (n = 0; n < 2; n = n + 1)
    begin
      rst = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      for (i = 0; i < 12; i = i + 1)
      begin
        mem[i] = 255;
        lk[i] = 0;
      end
      for (i = 0; i < 72; i = i + 1)
      begin
        w = (i < 12 || i >= 60) ? 0 : {$random(seed)} % 2;
        k = (i < 12 || i >= 60) ? i % 12 : {$random(seed)} % 15;
        a = k < 12 ? 24'hF80000 + 2 * k : k == 12 ? 24'hF80001 : k == 13 ? 24'hF80018 : 24'h800004;
        d = $random(seed);
        if (k == 7)
          d = d | 8'hC0;
        core.acc(w[0], a, d);
        b = (mem[k % 12] & mk[8 * (k % 12) +: 8]) | (k == 6 ? 8'hE0 : 8'h00);
        cmp_rd({hit, w ? 8'h00 : rdat}, {k < 12, w || k > 11 ? 8'h00 : b});
        cmp_rd({hit_s, w ? 8'h00 : rdat_s},
          {k < 12, w || k > 11 ? 8'h00 : b & (k == 5 ? 8'hDF : 8'hFF)});
        if (w && k < 12 && lk[k] == 0)
        begin
          mem[k] = mem[k] & d;
          lk[k] = 1;
        end
        b = mem[0] & 8'hCF;
        s = mem[1];
        e_end = b[2:1] == 2'b11 ? 24'h0 : b[2:1] == 2'b10 ? 24'h7FE
          : b[2:1] == 2'b01 ? 24'h1FFE : 24'h3FFE;
        e_ram = b[7:6] == 2'b11 ? 11'h0 : b[7:6] == 2'b10 ? 11'h80
          : b[7:6] == 2'b01 ? 11'h100 : 11'h400;
        cmp_dec({bwa, swa, sen, hs, send, ram}, {b[0], s[0], b[2:1] != 2'b11,
          b[2:1] != 2'b11 && !b[3], e_end, e_ram});
      end
      $display("power cycle %0d done", n);
    end
    end_of_test;
  end
  initial
  begin
    #(1000 * 50);
    bad_count = bad_count + 1;
    end_of_test;
  end
endmodule // tb_config_fuse_boot_protect
